// File: rtl/swv_pkg.sv
// shared constants and types for the scratchpad write/verify single-wire link
package swv_pkg;
  // ---------------------------------------------------------------
  // clock and times (ns as printed, cycles derived)
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS         = 8;     // 125 MHz
  localparam int unsigned T_LRST_STD_NS  = 120000; // line-low reset, standard
  localparam int unsigned T_LRST_OD_NS   = 16000;  // line-low reset, overdrive
  localparam int unsigned T_DSMP_STD_NS  = 30000;  // device sample point
  localparam int unsigned T_DSMP_OD_NS   = 3000;
  localparam int unsigned T_DHLD_STD_NS  = 30000;  // device hold of a zero
  localparam int unsigned T_DHLD_OD_NS   = 4000;
  localparam int unsigned T_HRST_STD_NS  = 480000; // host reset pulse
  localparam int unsigned T_HRST_OD_NS   = 48000;
  localparam int unsigned T_HSLOT_STD_NS = 70000;  // host slot incl recovery
  localparam int unsigned T_HSLOT_OD_NS  = 10000;
  localparam int unsigned T_HW0_STD_NS   = 60000;  // host write-zero low
  localparam int unsigned T_HW0_OD_NS    = 8000;
  localparam int unsigned T_HW1_STD_NS   = 6000;   // host write-one / read low
  localparam int unsigned T_HW1_OD_NS    = 1000;
  localparam int unsigned T_HSMP_STD_NS  = 13000;  // host read sample
  localparam int unsigned T_HSMP_OD_NS   = 2000;
  // least times round up
  localparam logic [16:0] LRST_STD_C  = 17'((T_LRST_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] LRST_OD_C   = 17'((T_LRST_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] DSMP_STD_C  = 17'((T_DSMP_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] DSMP_OD_C   = 17'((T_DSMP_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] DHLD_STD_C  = 17'((T_DHLD_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] DHLD_OD_C   = 17'((T_DHLD_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HRST_STD_C  = 17'((T_HRST_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HRST_OD_C   = 17'((T_HRST_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HSLOT_STD_C = 17'((T_HSLOT_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HSLOT_OD_C  = 17'((T_HSLOT_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HW0_STD_C   = 17'((T_HW0_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HW0_OD_C    = 17'((T_HW0_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HW1_STD_C   = 17'((T_HW1_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HW1_OD_C    = 17'((T_HW1_OD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HSMP_STD_C  = 17'((T_HSMP_STD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] HSMP_OD_C   = 17'((T_HSMP_OD_NS + CLK_NS - 1) / CLK_NS);
  // ---------------------------------------------------------------
  // commands, register layout, crc
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_WRITE_SP = 8'h0f;
  localparam logic [7:0]  CMD_READ_SP  = 8'haa;
  localparam logic [7:0]  CMD_READ_ID  = 8'h33;
  localparam logic [7:0]  TA_ALIGN_MSK = 8'hf8;  // alignment bits forced zero
  localparam logic [7:0]  ES_ONES      = 8'h5f;  // ending offset + dead bits
  localparam int unsigned ES_PF_BIT    = 5;
  localparam int unsigned ES_AA_BIT    = 7;
  localparam logic [7:0]  CRC8_POLY    = 8'h8c;   // x8+x5+x4+1, reflected
  localparam logic [15:0] CRC16_POLY   = 16'ha001; // x16+x15+x2+1, reflected
  localparam logic [3:0]  IDX_SP_ES    = 4'd2;
  localparam logic [3:0]  IDX_SP_DAT   = 4'd3;
  localparam logic [3:0]  IDX_WR_LAST  = 4'd9;
  localparam logic [3:0]  IDX_CRC_LO   = 4'd11;
  localparam logic [3:0]  IDX_CRC_HI   = 4'd12;
  localparam logic [3:0]  IDX_ID_CRC   = 4'd7;
  localparam logic [1:0]  HK_RESET     = 2'd0;
  localparam logic [1:0]  HK_WRITE     = 2'd1;
  localparam logic [1:0]  HK_READ      = 2'd2;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DS_CMD  = 4'h1, DS_WRX = 4'h2, DS_TX = 4'h4, DS_HALT = 4'h8
  } swv_dst_e;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1, HS_RST = 4'h2, HS_RCV = 4'h4, HS_SLOT = 4'h8
  } swv_hst_e;
  typedef enum logic [1:0] {TXM_READ, TXM_WCRC, TXM_ID} swv_txm_e;
endpackage

// File: rtl/swv_bus_if.sv
// single open-drain line joining the device end and the host end
`timescale 1ns/100ps
`default_nettype none
interface swv_bus_if;
  logic dq;        // resolved line level
  logic dev_out;   // device drive value
  logic dev_oe_n;  // device drives while low
  logic host_out;  // host drive value
  logic host_oe_n; // host drives while low
  // wired-and with pull-up: an end pulls only when enabled
  assign dq = (dev_oe_n | dev_out) & (host_oe_n | host_out);
  modport dev (input dq, output dev_out, output dev_oe_n);
  modport host (input dq, output host_out, output host_oe_n);
endinterface
`default_nettype wire

// File: rtl/swv_dev.sv
// device end: identity, address/status registers and scratchpad path
// Overview of operation
// - identity is family, 48-bit serial, crc8
// - crc8 x8+x5+x4+1, generator starts at zero
// - family lsb first, then serial bits
// - four 32-byte pages, secret, 8-byte scratchpad
// - two target address bytes hold address
// - low three address bits forced to zero
// - status bits 0-4 and 6 read one
// - partial flag on broken byte or power loss
// - valid scratchpad write clears partial flag
// - copy sets accepted flag, write clears it
// - write takes address then eight data bytes
// - master sends all eight bytes complete
// - inverted crc16 after eighth written byte
// - read sends address, status, then data
// - inverted crc16 follows read scratchpad data
// - master reads back and rewrites on flags
// - after verify master copies or changes secret
// - device is slave, master starts slots
// - idle line high, suspended master releases
// - long low line resets the device
// - every byte moves lsb first
`timescale 1ns/100ps
`default_nettype none
module swv_dev #(
  parameter logic [7:0]  FAMILY     = 8'h5a,          // arbitrary value
  parameter logic [47:0] SERIAL     = 48'h0123456789ab, // arbitrary value
  parameter logic [16:0] LRST_STD_CYC = swv_pkg::LRST_STD_C
) (
  // clock and reset
  input  wire logic         MCLK,
  input  wire logic         RST,
  // line
  swv_bus_if.dev            bus,
  // speed select from local logic
  input  wire logic         OVERDRIVE,
  // copy engine reports scratchpad copied
  input  wire logic         COPY_DONE,
  // register view for the memory side
  output logic      [7:0]   TARGET_LOW,
  output logic      [7:0]   TARGET_HIGH,
  output logic      [63:0]  SCRATCHPAD,
  output logic              PARTIAL_FLAG,
  output logic              AUTH_FLAG
);
  import swv_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    swv_dst_e        st;      // protocol state
    swv_txm_e        txm;     // what is being sent
    logic            s1;      // line sync stage 1
    logic            s2;      // line sync stage 2
    logic            s3;      // delayed for edge detect
    logic            in_slot; // inside a time slot
    logic            tx_slot; // slot opened while sending
    logic            drv_n;   // open-drain enable, low pulls
    logic [16:0]     cnt;     // cycles since slot edge
    logic [16:0]     low_cnt; // cycles line held low
    logic [3:0]      idx;     // byte index in sequence
    logic [2:0]      bit_i;   // bit index in byte
    logic [7:0]      sh;      // byte shifter
    logic [15:0]     crc16;   // scratchpad crc
    logic [7:0]      crc8;    // identity crc
    logic [7:0]      ta_lo;   // target_address_low
    logic [7:0]      ta_hi;   // target_address_high
    logic            pf;      // partial_byte_flag
    logic            aa;      // authorization_accepted_flag
    logic [7:0][7:0] sp;      // scratchpad bytes
  } swv_dev_s;

  swv_dev_s r;   // registered state
  swv_dev_s nx;  // next state

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one bit through the reflected crc16 generator
  function automatic logic [15:0] crc16_step(logic [15:0] c, logic b);
    logic fb;
    fb = c[0] ^ b;
    crc16_step = (c >> 1) ^ (fb ? CRC16_POLY : 16'h0000);
  endfunction

  // one bit through the identity crc generator
  function automatic logic [7:0] crc8_step(logic [7:0] c, logic b);
    logic fb;
    fb = c[0] ^ b;
    crc8_step = (c >> 1) ^ (fb ? CRC8_POLY : 8'h00);
  endfunction

  // byte to send for a given sequence position
  function automatic logic [7:0] tx_byte(swv_dev_s v, logic [3:0] i);
    logic [55:0] id;
    id = {SERIAL, FAMILY};
    tx_byte = 8'h00;
    if (v.txm == TXM_ID) begin
      // family goes first, lsb first, then serial, then crc
      if (i < IDX_ID_CRC) tx_byte = id[8 * i +: 8];
      else tx_byte = v.crc8;
    end else begin
      case (i)
        4'd0:        tx_byte = v.ta_lo;
        4'd1:        tx_byte = v.ta_hi;
        IDX_SP_ES:   tx_byte = ES_ONES | ({7'h00, v.pf} << ES_PF_BIT) |
                               ({7'h00, v.aa} << ES_AA_BIT);
        IDX_CRC_LO:  tx_byte = ~v.crc16[7:0];
        IDX_CRC_HI:  tx_byte = ~v.crc16[15:8];
        default:     tx_byte = v.sp[3'(i - IDX_SP_DAT)];
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic [16:0] smp_c;   // sample point for this speed
  logic [16:0] hld_c;   // end of device part of the slot
  logic [16:0] lrst_c;  // line-low reset threshold
  logic        rx_bit;  // bit sampled from line
  logic        tx_bit;  // bit being sent

  always_comb begin
    nx     = r;
    smp_c  = OVERDRIVE ? DSMP_OD_C : DSMP_STD_C;
    hld_c  = OVERDRIVE ? DHLD_OD_C : DHLD_STD_C;
    lrst_c = OVERDRIVE ? LRST_OD_C : LRST_STD_CYC;
    rx_bit = r.s2;
    tx_bit = r.sh[0];
    // two flops before any logic reads the line
    nx.s1 = bus.dq;
    nx.s2 = r.s1;
    nx.s3 = r.s2;

    // falling edge opens a slot; only the master makes it
    if (r.s3 && !r.s2 && !r.in_slot) begin
      nx.in_slot = 1'b1;
      nx.cnt     = 17'd0;
      // only a slot that opens in send state carries a sent bit
      nx.tx_slot = (r.st == DS_TX);
      // a zero is sent by holding the line low
      if (r.st == DS_TX && !tx_bit) nx.drv_n = 1'b0;
    end else if (r.in_slot) begin
      nx.cnt = r.cnt + 17'd1;
      // receive: sample the master's bit mid slot
      if (r.cnt == smp_c && (r.st == DS_CMD || r.st == DS_WRX)) begin
        nx.sh    = {rx_bit, r.sh[7:1]};
        nx.crc16 = crc16_step(r.crc16, rx_bit);
        nx.bit_i = r.bit_i + 3'd1;
        if (r.bit_i == 3'd7) begin
          nx.idx = r.idx + 4'd1;
          if (r.st == DS_CMD) begin
            nx.idx = 4'd0;
            // command byte picks the sequence
            case (nx.sh)
              CMD_WRITE_SP: nx.st = DS_WRX;
              CMD_READ_SP: begin
                nx.st  = DS_TX;
                nx.txm = TXM_READ;
                nx.sh  = tx_byte(nx, 4'd0);
              end
              CMD_READ_ID: begin
                nx.st  = DS_TX;
                nx.txm = TXM_ID;
                nx.sh  = tx_byte(nx, 4'd0);
              end
              default: nx.st = DS_HALT; // unknown: wait for reset
            endcase
          end else begin
            case (r.idx)
              4'd0:    nx.ta_lo = nx.sh & TA_ALIGN_MSK;
              4'd1:    nx.ta_hi = nx.sh;
              default: nx.sp[3'(r.idx - 4'd2)] = nx.sh;
            endcase
            // all eight bytes in: the write is valid
            if (r.idx == IDX_WR_LAST) begin
              nx.pf  = 1'b0;
              nx.aa  = 1'b0;
              nx.st  = DS_TX;
              nx.txm = TXM_WCRC;
              nx.idx = IDX_CRC_LO;
              nx.sh  = tx_byte(nx, IDX_CRC_LO);
            end
          end
        end
      end
      // end of device part of slot: release and advance
      if (r.cnt == hld_c) begin
        nx.in_slot = 1'b0;
        nx.drv_n   = 1'b1;
        // the slot that turned us to sending was a receive slot: no shift
        if (r.tx_slot) begin
          // crc runs over sent data, frozen over its own bytes
          if (r.txm != TXM_ID && r.idx < IDX_CRC_LO)
            nx.crc16 = crc16_step(r.crc16, tx_bit);
          if (r.txm == TXM_ID && r.idx < IDX_ID_CRC)
            nx.crc8 = crc8_step(r.crc8, tx_bit);
          nx.sh    = r.sh >> 1;
          nx.bit_i = r.bit_i + 3'd1;
          if (r.bit_i == 3'd7) begin
            nx.idx = r.idx + 4'd1;
            if ((r.txm == TXM_ID && r.idx == IDX_ID_CRC) ||
                (r.txm != TXM_ID && r.idx == IDX_CRC_HI))
              nx.st = DS_HALT;
            else
              nx.sh = tx_byte(nx, nx.idx);
          end
        end
      end
    end

    // long low on the line restarts the transaction
    if (!r.s2) begin
      if (r.low_cnt != 17'h1ffff) nx.low_cnt = r.low_cnt + 17'd1;
      if (r.low_cnt == lrst_c) begin
        // a byte cut short while writing marks partial data
        if (r.st == DS_WRX && r.bit_i != 3'd0) nx.pf = 1'b1;
        nx.st      = DS_CMD;
        nx.in_slot = 1'b0;
        nx.drv_n   = 1'b1;
        nx.idx     = 4'd0;
        nx.bit_i   = 3'd0;
        nx.crc16   = 16'h0000;
        nx.crc8    = 8'h00;
      end
    end else begin
      nx.low_cnt = 17'd0;
    end

    // copy done beats a same-cycle write clear
    if (COPY_DONE) nx.aa = 1'b1;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      r       <= '0;
      r.st    <= DS_CMD;
      r.txm   <= TXM_READ;
      r.s1    <= 1'b1;
      r.s2    <= 1'b1;
      r.s3    <= 1'b1;
      r.drv_n <= 1'b1;
      r.pf    <= 1'b1; // scratchpad invalid after power-up
    end else begin
      r <= nx;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.dev_out  = 1'b0;    // open drain only ever pulls low
  assign bus.dev_oe_n = r.drv_n;
  assign TARGET_LOW   = r.ta_lo;
  assign TARGET_HIGH  = r.ta_hi;
  assign SCRATCHPAD   = r.sp;
  assign PARTIAL_FLAG = r.pf;    // master acts on these
  assign AUTH_FLAG    = r.aa;
endmodule
`default_nettype wire

// File: rtl/swv_host.sv
// host end: reset pulses and byte slots on the single line
`timescale 1ns/100ps
`default_nettype none
module swv_host #(
  parameter logic [16:0] RST_STD_CYC  = swv_pkg::HRST_STD_C,
  parameter logic [16:0] RST_OD_CYC   = swv_pkg::HRST_OD_C,
  parameter logic [16:0] SLOT_STD_CYC = swv_pkg::HSLOT_STD_C,
  parameter logic [16:0] W0_STD_CYC   = swv_pkg::HW0_STD_C
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // line
  swv_bus_if.host          bus,
  // request port
  input  wire logic        OVERDRIVE,
  input  wire logic        REQ_VALID,
  input  wire logic [1:0]  REQ_KIND,
  input  wire logic [7:0]  REQ_DATA,
  // answers
  output logic             BUSY,
  output logic             DONE,
  output logic      [7:0]  RSP_DATA,
  output logic      [7:0]  CRC8_ACC,
  output logic      [15:0] CRC16_ACC
);
  import swv_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    swv_hst_e    st;    // sequencer state
    logic        s1;    // line sync stage 1
    logic        s2;    // line sync stage 2
    logic        rd;    // current byte is a read
    logic        drv_n; // low pulls the line
    logic [16:0] cnt;   // cycles in phase
    logic [2:0]  bit_i; // bit within byte
    logic [7:0]  sh;    // byte shifter
    logic        busy;  // request in progress
    logic        done;  // one-cycle completion
    logic [7:0]  rsp;   // last byte
    logic [7:0]  crc8;  // running identity crc
    logic [15:0] crc16; // running scratchpad crc
  } swv_host_s;

  swv_host_s r;
  swv_host_s nx;

  // reflected crc steps shared with the device side meaning
  function automatic logic [15:0] c16(logic [15:0] c, logic b);
    c16 = (c >> 1) ^ ((c[0] ^ b) ? CRC16_POLY : 16'h0000);
  endfunction
  function automatic logic [7:0] c8(logic [7:0] c, logic b);
    c8 = (c >> 1) ^ ((c[0] ^ b) ? CRC8_POLY : 8'h00);
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  logic [16:0] rst_c;  // reset low time for this speed
  logic [16:0] slot_c; // full slot
  logic [16:0] low_c;  // low time for this bit
  logic [16:0] smp_c;  // read sample point

  always_comb begin
    nx     = r;
    rst_c  = OVERDRIVE ? RST_OD_CYC : RST_STD_CYC;
    slot_c = OVERDRIVE ? HSLOT_OD_C : SLOT_STD_CYC;
    smp_c  = OVERDRIVE ? HSMP_OD_C : HSMP_STD_C;
    // a one or a read is a short low, a zero a long one
    if (r.rd || r.sh[0]) low_c = OVERDRIVE ? HW1_OD_C : HW1_STD_C;
    else low_c = OVERDRIVE ? HW0_OD_C : W0_STD_CYC;
    nx.s1   = bus.dq;
    nx.s2   = r.s1;
    nx.done = 1'b0;
    nx.cnt  = r.cnt + 17'd1;
    case (r.st)
      HS_IDLE: begin
        nx.drv_n = 1'b1; // idle leaves line released
        nx.cnt   = 17'd0;
        if (REQ_VALID) begin
          nx.busy  = 1'b1;
          nx.sh    = REQ_DATA;
          nx.rd    = (REQ_KIND == HK_READ);
          nx.bit_i = 3'd0;
          nx.drv_n = 1'b0; // first falling edge is ours
          if (REQ_KIND == HK_RESET) begin
            nx.st    = HS_RST;
            nx.crc8  = 8'h00;
            nx.crc16 = 16'h0000;
          end else begin
            nx.st = HS_SLOT;
          end
        end
      end
      HS_RST: begin
        if (r.cnt == rst_c) begin
          nx.drv_n = 1'b1;
          nx.cnt   = 17'd0;
          nx.st    = HS_RCV;
        end
      end
      HS_RCV: begin
        if (r.cnt == rst_c) begin
          nx.st   = HS_IDLE;
          nx.busy = 1'b0;
          nx.done = 1'b1;
        end
      end
      HS_SLOT: begin
        if (r.cnt == low_c) nx.drv_n = 1'b1;
        // device answer sampled early in the slot, at smp_c (13 of 70 us, 2 of 10 us overdrive), lsb first
        if (r.rd && r.cnt == smp_c) begin
          nx.sh    = {r.s2, r.sh[7:1]};
          nx.crc8  = c8(r.crc8, r.s2);
          nx.crc16 = c16(r.crc16, r.s2);
        end
        if (r.cnt == slot_c) begin
          nx.cnt   = 17'd0;
          nx.bit_i = r.bit_i + 3'd1;
          if (!r.rd) begin
            nx.sh    = r.sh >> 1;
            nx.crc8  = c8(r.crc8, r.sh[0]);
            nx.crc16 = c16(r.crc16, r.sh[0]);
          end
          if (r.bit_i == 3'd7) begin
            // whole byte only: partial bytes never leave here
            nx.st   = HS_IDLE;
            nx.busy = 1'b0;
            nx.done = 1'b1;
            nx.rsp  = r.sh; // read byte, or leftover of a write
          end else begin
            nx.drv_n = 1'b0; // next slot edge
          end
        end
      end
      default: nx.st = HS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      r       <= '0;
      r.st    <= HS_IDLE;
      r.s1    <= 1'b1;
      r.s2    <= 1'b1;
      r.drv_n <= 1'b1;
    end else begin
      r <= nx;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.host_out  = 1'b0;
  assign bus.host_oe_n = r.drv_n;
  assign BUSY          = r.busy;
  assign DONE          = r.done;
  assign RSP_DATA      = r.rsp;
  assign CRC8_ACC      = r.crc8;
  assign CRC16_ACC     = r.crc16;
endmodule
`default_nettype wire

// File: testbench/swv_asserts.sv
// wire-level checks for the single-line link
`timescale 1ns/100ps
`default_nettype none
module swv_asserts #(
  parameter int RST_CYC = 2500  // host line-reset length
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // line and drivers
  input wire logic dq,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic host_out,
  input wire logic host_oe_n
);
  logic [15:0] low_cnt_r;  // length of current low run
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // low-run counter; runs stay far below 16 bits
  always_ff @(posedge MCLK) begin
    if (RST || dq) low_cnt_r <= 16'h0000;
    else low_cnt_r <= low_cnt_r + 16'h0001;
  end
  property p_wired; dq == ((dev_oe_n | dev_out) & (host_oe_n | host_out)); endproperty
  a_wired: assert property (p_wired) else $error("line level wrong");
  property p_drain; !dev_out && !host_out; endproperty
  a_drain: assert property (p_drain) else $error("end drives a one");
  property p_rel; $fell(RST) |-> dev_oe_n && host_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("line held after reset");
  property p_slave; $fell(dev_oe_n) |-> !host_oe_n; endproperty
  a_slave: assert property (p_slave) else $error("device opened a slot");
  property p_dhold; $fell(dev_oe_n) |=> !dev_oe_n [*8]; endproperty
  a_dhold: assert property (p_dhold) else $error("device zero too short");
  property p_dfree; $fell(dev_oe_n) |-> ##[1:600] dev_oe_n; endproperty
  a_dfree: assert property (p_dfree) else $error("device holds line");
  property p_hmin; $fell(host_oe_n) |=> !host_oe_n [*8]; endproperty
  a_hmin: assert property (p_hmin) else $error("host pulse too short");
  property p_lowmax; low_cnt_r <= RST_CYC + 16; endproperty
  a_lowmax: assert property (p_lowmax) else $error("line low too long");
  property p_quiet; (low_cnt_r > 16'd1000) |-> dev_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("device drives in reset");
  c_dev: cover property ($fell(dev_oe_n));
  c_host: cover property ($fell(host_oe_n));
  c_lrst: cover property (low_cnt_r > 16'd2000);
endmodule
`default_nettype wire

// File: testbench/test_scratchpad_write_verify_id.sv
// self-checking bench joining device and host ends
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, ex, got); end end
module test_scratchpad_write_verify_id;
  import swv_pkg::*;
  localparam logic [7:0]  FAM = 8'h3c;            // arbitrary value
  localparam logic [47:0] SER = 48'h9e2b17c4d05a; // arbitrary value
  logic        mclk = 1'b0, rst = 1'b1, rv = 1'b0, cpd = 1'b0, done, pf, aa, busy;
  logic [1:0]  rk = 2'h0;
  logic [7:0]  rd_d = 8'h00, q, tlo, thi, c8, h8, hc8, tx [0:10], ex [0:10];
  logic [15:0] c16, hc16;
  logic [63:0] sp;
  logic [31:0] rnd = 32'h72cdf0f8;
  int          err_total = 0, n_tests = 0, cyc = 0;
  swv_bus_if swv_bus_if_i ();
  // overdrive on both ends keeps slots short
  swv_dev #(.FAMILY(FAM), .SERIAL(SER)) swv_dev_i (.MCLK(mclk), .RST(rst), .bus(swv_bus_if_i.dev),
    .OVERDRIVE(1'b1), .COPY_DONE(cpd), .TARGET_LOW(tlo), .TARGET_HIGH(thi), .SCRATCHPAD(sp),
    .PARTIAL_FLAG(pf), .AUTH_FLAG(aa));
  swv_host #(.RST_OD_CYC(17'd2500)) swv_host_i (.MCLK(mclk), .RST(rst), .bus(swv_bus_if_i.host),
    .OVERDRIVE(1'b1), .REQ_VALID(rv), .REQ_KIND(rk), .REQ_DATA(rd_d), .BUSY(busy), .DONE(done),
    .RSP_DATA(q), .CRC8_ACC(hc8), .CRC16_ACC(hc16));
  swv_asserts #(.RST_CYC(2500)) swv_asserts_i (.MCLK(mclk), .RST(rst), .dq(swv_bus_if_i.dq),
    .dev_out(swv_bus_if_i.dev_out), .dev_oe_n(swv_bus_if_i.dev_oe_n),
    .host_out(swv_bus_if_i.host_out), .host_oe_n(swv_bus_if_i.host_oe_n));
  always #4 mclk = ~mclk;
  // verdict in one place
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 600000) begin
      err_total++;
      $display("Error watchdog exp done got hang");
      tally_and_finish();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // reflected crc step; narrow codes ride in the low bits
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b, input logic [15:0] p);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ p) : (c >> 1);
    return c;
  endfunction
  // one host request, held one edge, then wait for its done pulse
  task automatic xfer(input logic [1:0] k, input logic [7:0] d);
    @(negedge mclk);
    rv = 1'b1;
    rk = k;
    rd_d = d;
    @(negedge mclk);
    rv = 1'b0;
    `CHK("busy", 1'b1, busy)
    while (done !== 1'b1) @(negedge mclk);
    `CHK("idle", 1'b0, busy)
  endtask
  // line reset, nw bytes out, nr bytes in against ex
  task automatic run(input int nw, input int nr);
    xfer(HK_RESET, 8'h00);
    c8 = 8'h00;
    h8 = 8'h00;
    c16 = 16'h0000;
    for (int i = 0; i < nw; i++) begin
      xfer(HK_WRITE, tx[i]);
      h8 = 8'(crc({8'h00, h8}, tx[i], 16'h008c));
      c16 = crc(c16, tx[i], 16'ha001);
    end
    for (int i = 0; i < nr; i++) begin
      xfer(HK_READ, 8'hff);
      `CHK("rx byte", ex[i], q)
      c8 = 8'(crc({8'h00, c8}, ex[i], 16'h008c));
      h8 = 8'(crc({8'h00, h8}, ex[i], 16'h008c));
      c16 = crc(c16, ex[i], 16'ha001);
    end
    // host accumulators cover every byte since the line reset
    `CHK("host crc8", h8, hc8)
    `CHK("host crc16", c16, hc16)
  endtask
  // inverted crc16, low byte first
  task automatic chk16;
    xfer(HK_READ, 8'hff);
    `CHK("crc lo", ~c16[7:0], q)
    xfer(HK_READ, 8'hff);
    `CHK("crc hi", ~c16[15:8], q)
  endtask
  // copy engine reports the verified scratchpad moved
  task automatic copy;
    @(negedge mclk);
    cpd = 1'b1;
    @(negedge mclk);
    cpd = 1'b0;
    @(negedge mclk);
    `CHK("copied flag", 1'b1, aa)
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    `CHK("partial at power-up", 1'b1, pf)
    // identity: family, serial, then its crc
    tx[0] = CMD_READ_ID;
    for (int i = 0; i < 7; i++) ex[i] = 8'({SER, FAM} >> (8 * i));
    run(1, 7);
    xfer(HK_READ, 8'hff);
    `CHK("id crc", c8, q)
    copy();
    // write with misaligned low address on purpose
    tx[0] = CMD_WRITE_SP;
    for (int i = 1; i < 11; i++) begin
      rnd = xs(rnd);
      tx[i] = rnd[7:0];
    end
    tx[1] = tx[1] | 8'h07;
    run(11, 0);
    chk16();
    `CHK("low address", tx[1] & 8'hf8, tlo)
    `CHK("high address", tx[2], thi)
    for (int i = 0; i < 8; i++) `CHK("scratch byte", tx[i + 3], sp[8 * i +: 8])
    `CHK("flags", 2'b00, {pf, aa})
    copy();
    // read back: address, status with copied flag, data
    ex[0] = tx[1] & 8'hf8;
    ex[1] = tx[2];
    ex[2] = 8'hdf;
    for (int i = 3; i < 11; i++) ex[i] = tx[i];
    tx[0] = CMD_READ_SP;
    run(1, 11);
    chk16();
    tally_and_finish();
  end
endmodule
`default_nettype wire
